// file: scc_pkg.sv
// constants and types of the serial channel control block
package scc_pkg;
  // register offsets (byte addresses)
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] DATA_OFS = 8'h04;
  localparam logic [7:0] MODE_OFS = 8'h08;
  // channel_control field positions
  localparam int B_HOLD  = 12;
  localparam int B_ULVL  = 10;
  localparam int B_IDLE  = 8;
  localparam int B_NINTH = 7;
  localparam int B_EVEN  = 6;
  localparam int B_PAREN = 5;
  localparam int B_OVR   = 4;
  localparam int B_PARITY_UNDERRUN_FLAG  = 3;
  localparam int B_FRAMING_FLAG  = 2;
  localparam int B_EDGE  = 1;
  localparam int B_SRC   = 0;
  // values after reset
  localparam logic       ULVL_RST = 1'b1;
  localparam logic [1:0] IDLE_RST = 2'h2;
  localparam logic [1:0] MODE_RST = 2'h0;
  // transfer_mode_sel codes
  localparam logic [1:0] MODE_IO = 2'h0;
  localparam logic [1:0] MODE_U7 = 2'h1;
  localparam logic [1:0] MODE_U8 = 2'h2;
  localparam logic [1:0] MODE_U9 = 2'h3;
  // idle settings after the final bit
  localparam logic [1:0] IDLE_LOW  = 2'h0;
  localparam logic [1:0] IDLE_HIGH = 2'h1;
  localparam logic [1:0] IDLE_KEEP = 2'h2;
  // final-bit hold, in high_speed_clock_ref periods (one per clk_i)
  localparam logic [7:0] HOLD_BASE_CYC = 8'h02;
  localparam logic [7:0] HOLD_MAX_CYC  = 8'h80;
  localparam logic [2:0] HOLD_RSVD     = 3'h7;

  typedef enum logic [2:0] {
    RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP
  } scc_rx_e;

  typedef struct packed {
    logic [2:0]  hold_sel;
    logic        under_lvl;
    logic [1:0]  idle_sel;
    logic        even;
    logic        par_en;
    logic        edge_sel;
    logic        clk_src;
    logic [1:0]  mode;
    logic        ninth;
    logic        ovr;
    logic        parity_underrun_flag;
    logic        framing_flag;
    logic [7:0]  rx_data;
    logic        rx_full;
    logic        ack;
    logic [31:0] dat;
    logic [7:0]  sh;
    logic [3:0]  bitn;
    logic [3:0]  sbit;
    logic [7:0]  rsh;
    logic        busy;
    logic        holding;
    logic [7:0]  hcnt;
    logic        sclk;
    logic        sprev;
    logic [7:0]  div;
    logic        txd;
    logic        oe;
    scc_rx_e     rst;
    logic [15:0] rcnt;
    logic [3:0]  rbit;
    logic [8:0]  rsh9;
  } scc_state_s;
endpackage

// file: scc_channel_control.sv
// serial channel control register, shift port and uart receiver
//
// The address map and register access over Wishbone are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

module scc_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // fill side
  input  wire logic         in_vld_i,
  output logic              in_rdy_o,
  input  wire logic [W-1:0] in_dat_i,
  // drain side
  output logic              out_vld_o,
  input  wire logic         out_rdy_i,
  output logic [W-1:0]      out_dat_o
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam logic [AW-1:0] LAST = AW'(D - 1);
  localparam logic [AW:0]   FULL = (AW + 1)'(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } scc_fifo_s;

  scc_fifo_s r_reg;
  scc_fifo_s r_next;
  logic      push;
  logic      pop;

  assign in_rdy_o  = (r_reg.cnt != FULL);
  assign out_vld_o = (r_reg.cnt != '0);
  assign out_dat_o = r_reg.mem[r_reg.rp];

  always_comb begin
    r_next = r_reg;
    push = in_vld_i & in_rdy_o;
    pop  = out_vld_o & out_rdy_i;
    if (push) begin
      r_next.mem[r_reg.wp] = in_dat_i;
      r_next.wp = (r_reg.wp == LAST) ? '0 : r_reg.wp + 1'b1;
    end
    if (pop) begin
      r_next.rp = (r_reg.rp == LAST) ? '0 : r_reg.rp + 1'b1;
    end
    if (push & ~pop) begin
      r_next.cnt = r_reg.cnt + 1'b1;
    end else if (pop & ~push) begin
      r_next.cnt = r_reg.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end
endmodule // scc_fifo

module scc_channel_control #(
  parameter int SCLK_HALF  = 4,
  parameter int BIT_CYC    = 347,
  parameter int FIFO_DEPTH = 8
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [31:0] dat_i,
  input  wire logic [3:0]  sel_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  // serial pins
  output logic             serial_out_pin_o,
  input  wire logic        serial_in_pin_i,
  input  wire logic        shift_clock_pin_i,
  output logic             shift_clock_pin_o,
  output logic             shift_clock_pin_oe_o
);
  scc_pkg::scc_state_s r_reg;
  scc_pkg::scc_state_s r_next;

  logic       f_in_rdy;
  logic       f_out_vld;
  logic       f_out_rdy;
  logic [7:0] f_out_dat;
  logic       f_push;
  logic       acc;
  logic       hit_ctrl;
  logic       hit_data;
  logic       hit_mode;
  logic       wr;
  logic       rd;
  logic       clr_flags;
  logic       io;
  logic       ext;
  logic       s_now;
  logic       sh_edge;
  logic       sm_edge;
  logic       io_done;
  logic       underrun;
  logic       set_ovr;
  logic       set_parity_underrun_flag;
  logic       set_framing_flag;
  logic       u_done;
  logic       par_on;

  function automatic logic [7:0] hold_cyc(input logic [2:0] c);
    // reserved code falls back to the longest hold
    if (c == scc_pkg::HOLD_RSVD) begin
      hold_cyc = scc_pkg::HOLD_MAX_CYC;
    end else begin
      hold_cyc = 8'(scc_pkg::HOLD_BASE_CYC << c);
    end
  endfunction

  function automatic logic idle_lvl(input logic [1:0] s, input logic last);
    case (s)
      scc_pkg::IDLE_LOW:  idle_lvl = 1'b0;
      scc_pkg::IDLE_HIGH: idle_lvl = 1'b1;
      default:            idle_lvl = last;
    endcase
  endfunction

  function automatic logic [3:0] data_bits(input logic [1:0] m);
    case (m)
      scc_pkg::MODE_U7: data_bits = 4'h7;
      scc_pkg::MODE_U9: data_bits = 4'h9;
      default:          data_bits = 4'h8;
    endcase
  endfunction

  scc_fifo #(
    .W (8),
    .D (FIFO_DEPTH)
  ) u_tx_fifo (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .in_vld_i  (f_push),
    .in_rdy_o  (f_in_rdy),
    .in_dat_i  (dat_i[7:0]),
    .out_vld_o (f_out_vld),
    .out_rdy_i (f_out_rdy),
    .out_dat_o (f_out_dat)
  );

  assign dat_o                = r_reg.dat;
  assign ack_o                = r_reg.ack;
  assign serial_out_pin_o     = r_reg.txd;
  assign shift_clock_pin_o    = r_reg.sclk;
  assign shift_clock_pin_oe_o = r_reg.oe;

  always_comb begin
    r_next   = r_reg;
    acc      = cyc_i & stb_i;
    hit_ctrl = (adr_i == scc_pkg::CTRL_OFS);
    hit_data = (adr_i == scc_pkg::DATA_OFS);
    hit_mode = (adr_i == scc_pkg::MODE_OFS);
    wr       = r_reg.ack & acc & we_i;
    // reads act at capture, so an event in the ack cycle is not lost
    rd       = acc & ~r_reg.ack & ~we_i;
    clr_flags = rd & hit_ctrl;
    f_push   = wr & hit_data & sel_i[0];
    io       = (r_reg.mode == scc_pkg::MODE_IO);
    ext      = r_reg.clk_src;
    par_on   = r_reg.par_en & (r_reg.mode != scc_pkg::MODE_U9);
    s_now    = ext ? shift_clock_pin_i : r_reg.sclk;
    sh_edge  = io & (r_reg.edge_sel ? (s_now & ~r_reg.sprev)
                                    : (~s_now & r_reg.sprev));
    sm_edge  = io & (r_reg.edge_sel ? (~s_now & r_reg.sprev)
                                    : (s_now & ~r_reg.sprev));
    f_out_rdy = io & ~r_reg.busy & ~r_reg.holding;
    io_done  = r_reg.busy & sm_edge & (r_reg.sbit == 4'h7);
    underrun = io & ext & sh_edge & ~r_reg.busy & ~r_reg.holding
             & ~f_out_vld;
    u_done   = 1'b0;
    set_ovr  = 1'b0;
    set_parity_underrun_flag = underrun;
    set_framing_flag = 1'b0;
    r_next.sprev = s_now;
    r_next.oe    = io & ~r_reg.clk_src;

    // bus: a data write waits for fifo room, so the master is stalled
    r_next.ack = acc & ~r_reg.ack & (~(we_i & hit_data) | f_in_rdy);
    if (acc & ~r_reg.ack) begin
      r_next.dat = '0;
      if (hit_ctrl) begin
        r_next.dat[scc_pkg::B_HOLD+:3] = r_reg.hold_sel;
        r_next.dat[scc_pkg::B_ULVL]    = r_reg.under_lvl;
        r_next.dat[scc_pkg::B_IDLE+:2] = r_reg.idle_sel;
        r_next.dat[scc_pkg::B_NINTH]   = r_reg.ninth;
        r_next.dat[scc_pkg::B_EVEN]    = r_reg.even;
        r_next.dat[scc_pkg::B_PAREN]   = r_reg.par_en;
        r_next.dat[scc_pkg::B_OVR]     = r_reg.ovr;
        r_next.dat[scc_pkg::B_PARITY_UNDERRUN_FLAG]    = r_reg.parity_underrun_flag;
        r_next.dat[scc_pkg::B_FRAMING_FLAG]    = r_reg.framing_flag;
        r_next.dat[scc_pkg::B_EDGE]    = r_reg.edge_sel;
        r_next.dat[scc_pkg::B_SRC]     = r_reg.clk_src;
      end else if (hit_data) begin
        r_next.dat[7:0] = r_reg.rx_data;
      end else if (hit_mode) begin
        r_next.dat[1:0] = r_reg.mode;
      end
    end
    if (wr & hit_ctrl & sel_i[1]) begin
      r_next.hold_sel  = dat_i[scc_pkg::B_HOLD+:3];
      r_next.under_lvl = dat_i[scc_pkg::B_ULVL];
      r_next.idle_sel  = dat_i[scc_pkg::B_IDLE+:2];
    end
    if (wr & hit_ctrl & sel_i[0]) begin
      r_next.even     = dat_i[scc_pkg::B_EVEN];
      r_next.par_en   = dat_i[scc_pkg::B_PAREN];
      r_next.edge_sel = dat_i[scc_pkg::B_EDGE];
      r_next.clk_src  = dat_i[scc_pkg::B_SRC];
    end
    if (wr & hit_mode & sel_i[0]) begin
      r_next.mode = dat_i[1:0];
    end
    if (rd & hit_data) begin
      r_next.rx_full = 1'b0;
    end

    // internal shift clock, parked at the idle level between bytes
    if (io & ~ext & r_reg.busy) begin
      if (r_reg.div == 8'h00) begin
        r_next.sclk = ~r_reg.sclk;
        r_next.div  = 8'(SCLK_HALF - 1);
      end else begin
        r_next.div = r_reg.div - 8'h01;
      end
    end else begin
      r_next.sclk = ~r_reg.edge_sel;
      r_next.div  = 8'(SCLK_HALF - 1);
    end

    // shift port transmit and receive
    if (f_out_vld & f_out_rdy) begin
      r_next.txd  = f_out_dat[0];
      r_next.sh   = {1'b0, f_out_dat[7:1]};
      r_next.bitn = 4'h0;
      r_next.sbit = 4'h0;
      r_next.busy = 1'b1;
    end else if (underrun) begin
      r_next.txd = r_reg.under_lvl;
    end else if (r_reg.busy) begin
      // bit0 stands from the load, so the first shift edge keeps it
      if (sh_edge & (r_reg.sbit != 4'h0) & (r_reg.bitn != 4'h7)) begin
        r_next.txd  = r_reg.sh[0];
        r_next.sh   = {1'b0, r_reg.sh[7:1]};
        r_next.bitn = r_reg.bitn + 4'h1;
      end
      if (sm_edge) begin
        r_next.rsh  = {serial_in_pin_i, r_reg.rsh[7:1]};
        r_next.sbit = r_reg.sbit + 4'h1;
      end
      if (io_done) begin
        r_next.busy = 1'b0;
        r_next.rx_data = {serial_in_pin_i, r_reg.rsh[7:1]};
        r_next.rx_full = 1'b1;
        set_ovr = r_reg.rx_full & ~(rd & hit_data);
        if (ext) begin
          r_next.holding = 1'b1;
          r_next.hcnt    = hold_cyc(r_reg.hold_sel) - 8'h01;
        end else begin
          r_next.txd = idle_lvl(r_reg.idle_sel, r_reg.txd);
        end
      end
    end else if (r_reg.holding) begin
      // keep-last-bit idle leaves the final bit on the pin after any hold code
      if (r_reg.hcnt == 8'h00) begin
        r_next.holding = 1'b0;
        r_next.txd = idle_lvl(r_reg.idle_sel, r_reg.txd);
      end else begin
        r_next.hcnt = r_reg.hcnt - 8'h01;
      end
    end

    // uart receiver, sampled in the middle of each bit
    if (r_reg.rcnt != 16'h0000) begin
      r_next.rcnt = r_reg.rcnt - 16'h0001;
    end
    case (r_reg.rst)
      scc_pkg::RX_IDLE: begin
        if (~io & ~serial_in_pin_i) begin
          r_next.rst  = scc_pkg::RX_START;
          r_next.rcnt = 16'(BIT_CYC / 2);
          r_next.rsh9 = '0;
          r_next.rbit = 4'h0;
        end
      end
      scc_pkg::RX_START: begin
        if (r_reg.rcnt == 16'h0000) begin
          r_next.rst  = serial_in_pin_i ? scc_pkg::RX_IDLE
                                        : scc_pkg::RX_DATA;
          r_next.rcnt = 16'(BIT_CYC - 1);
        end
      end
      scc_pkg::RX_DATA: begin
        if (r_reg.rcnt == 16'h0000) begin
          r_next.rsh9[r_reg.rbit] = serial_in_pin_i;
          r_next.rbit = r_reg.rbit + 4'h1;
          r_next.rcnt = 16'(BIT_CYC - 1);
          if (r_reg.rbit == data_bits(r_reg.mode) - 4'h1) begin
            r_next.rst = par_on ? scc_pkg::RX_PAR : scc_pkg::RX_STOP;
          end
        end
      end
      scc_pkg::RX_PAR: begin
        if (r_reg.rcnt == 16'h0000) begin
          set_parity_underrun_flag = ((^r_reg.rsh9) ^ serial_in_pin_i)
                   != ~r_reg.even;
          r_next.rst  = scc_pkg::RX_STOP;
          r_next.rcnt = 16'(BIT_CYC - 1);
        end
      end
      scc_pkg::RX_STOP: begin
        if (r_reg.rcnt == 16'h0000) begin
          u_done   = 1'b1;
          set_framing_flag = ~serial_in_pin_i;
          set_ovr  = r_reg.rx_full & ~(rd & hit_data);
          r_next.rx_data = r_reg.rsh9[7:0];
          r_next.rx_full = 1'b1;
          if (r_reg.mode == scc_pkg::MODE_U9) begin
            r_next.ninth = r_reg.rsh9[8];
          end
          r_next.rst = scc_pkg::RX_IDLE;
        end
      end
      default: r_next.rst = scc_pkg::RX_IDLE;
    endcase

    // a new fault wins over a clearing read in the same cycle
    r_next.ovr  = (r_reg.ovr  & ~clr_flags) | set_ovr;
    r_next.parity_underrun_flag = (r_reg.parity_underrun_flag & ~clr_flags) | set_parity_underrun_flag;
    r_next.framing_flag = (r_reg.framing_flag & ~clr_flags) | set_framing_flag;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg           <= '0;
      r_reg.under_lvl <= scc_pkg::ULVL_RST;
      r_reg.idle_sel  <= scc_pkg::IDLE_RST;
      r_reg.mode      <= scc_pkg::MODE_RST;
      r_reg.sclk      <= 1'b1;
      r_reg.sprev     <= 1'b1;
      r_reg.txd       <= 1'b1;
      r_reg.oe        <= 1'b1;
      r_reg.rst       <= scc_pkg::RX_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_hold2;
    $stable(serial_out_pin_o) [*2];
  endsequence
  sequence s_go_low;
    serial_out_pin_o == 1'b0;
  endsequence

  property p_hold_min;
    (io_done && ext && r_reg.hold_sel == 3'h0
     && r_reg.idle_sel == scc_pkg::IDLE_LOW)
      |=> s_hold2 ##1 s_go_low;
  endproperty
  a_hold_min: assert property (p_hold_min)
    else $error("final bit hold not two cycles");

  property p_underrun_lvl;
    underrun |=> serial_out_pin_o == $past(r_reg.under_lvl);
  endproperty
  a_underrun_lvl: assert property (p_underrun_lvl)
    else $error("under-run level wrong");

  property p_idle_int;
    (io_done && !ext && r_reg.idle_sel == scc_pkg::IDLE_HIGH)
      |=> serial_out_pin_o;
  endproperty
  a_idle_int: assert property (p_idle_int)
    else $error("idle high not applied");

  property p_ninth;
    (u_done && r_reg.mode == scc_pkg::MODE_U9)
      |=> r_reg.ninth == $past(r_reg.rsh9[8]);
  endproperty
  a_ninth: assert property (p_ninth)
    else $error("ninth bit not captured");

  property p_overrun;
    (set_ovr) |=> r_reg.ovr && r_reg.rx_full;
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("overrun not flagged");

  property p_read_clear;
    (clr_flags && !set_ovr && !set_parity_underrun_flag && !set_framing_flag)
      |=> !r_reg.ovr && !r_reg.parity_underrun_flag && !r_reg.framing_flag;
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("flags not cleared by read");

  property p_sticky;
    (r_reg.framing_flag && !clr_flags) |=> r_reg.framing_flag;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("framing flag dropped early");

  property p_framing;
    (r_reg.rst == scc_pkg::RX_STOP && r_reg.rcnt == 16'h0000
     && !serial_in_pin_i) |=> r_reg.framing_flag;
  endproperty
  a_framing: assert property (p_framing)
    else $error("framing error not flagged");

  property p_sclk_idle;
    (!r_reg.busy && io && !ext) ##1 (!r_reg.busy && io && !ext)
      |-> shift_clock_pin_o == ~$past(r_reg.edge_sel);
  endproperty
  a_sclk_idle: assert property (p_sclk_idle)
    else $error("shift clock idle level wrong");

  property p_oe_src;
    shift_clock_pin_oe_o == $past(io && !r_reg.clk_src);
  endproperty
  a_oe_src: assert property (p_oe_src)
    else $error("clock pin enable wrong");

  property p_parity;
    (r_reg.rst == scc_pkg::RX_PAR && r_reg.rcnt == 16'h0000
     && (((^r_reg.rsh9) ^ serial_in_pin_i) == r_reg.even))
      |=> r_reg.parity_underrun_flag;
  endproperty
  a_parity: assert property (p_parity)
    else $error("parity error not flagged");
endmodule // scc_channel_control

`default_nettype wire

// file: scc_ext_dev.sv
// external serial device model on data and clock pins
`timescale 1ns/100ps
`default_nettype none

module scc_ext_dev #(
  parameter int H = 4,
  parameter int B = 16
) (
  // clock
  input  wire logic clk_i,
  // pins
  input  wire logic serial_out_pin_i,
  output logic      serial_in_pin_o,
  output logic      shift_clock_pin_o
);
  initial begin
    serial_in_pin_o = 1'b1;
    shift_clock_pin_o = 1'b1;
  end

  // clock stands still at idle level outside bytes
  task automatic park(input logic es);
    @(posedge clk_i);
    shift_clock_pin_o <= ~es;
    repeat (H) @(posedge clk_i);
  endtask

  // leading edge shifts, trailing edge samples
  task automatic shift_byte(input logic [7:0] tx, input logic es,
                            output logic [7:0] rx);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_i);
      serial_in_pin_o <= tx[i];
      shift_clock_pin_o <= es;
      repeat (H) @(posedge clk_i);
      rx[i] = serial_out_pin_i;
      shift_clock_pin_o <= ~es; // half period kept >= hold time
      repeat (H - 1) @(posedge clk_i);
    end
    // released line must not look like a held bit
    serial_in_pin_o <= ~tx[7];
    repeat (H) @(posedge clk_i);
  endtask

  task automatic line_idle;
    @(posedge clk_i);
    serial_in_pin_o <= 1'b1;
    repeat (B) @(posedge clk_i);
  endtask

  task automatic uart_frame(input logic [8:0] d, input int nb,
                            input logic hp, input logic pb,
                            input logic stp);
    @(posedge clk_i);
    serial_in_pin_o <= 1'b0;
    repeat (B) @(posedge clk_i);
    for (int i = 0; i < nb; i++) begin
      serial_in_pin_o <= d[i];
      repeat (B) @(posedge clk_i);
    end
    if (hp) begin
      serial_in_pin_o <= pb;
      repeat (B) @(posedge clk_i);
    end
    serial_in_pin_o <= stp;
    repeat (B) @(posedge clk_i);
    serial_in_pin_o <= 1'b1;
    repeat (2 * B) @(posedge clk_i);
  endtask
endmodule // scc_ext_dev

`default_nettype wire

// file: tb_top.sv
// self-checking bench of the serial channel control block
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [3:0]  sel = 4'h0;
  logic [31:0] rdat;
  logic        ack;
  logic        sout;
  logic        sin;
  logic        sclk_in;
  logic        sclk_out;
  logic        sclk_oe;
  int          n_errors = 0;
  int          cmp_count = 0;
  int          cyc_cnt = 0;

  always #12.5 clk_i = ~clk_i;

  scc_channel_control #(.SCLK_HALF(2), .BIT_CYC(16))
    scc_channel_control_i (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .dat_i(wdat), .sel_i(sel), .dat_o(rdat), .ack_o(ack),
    .serial_out_pin_o(sout), .serial_in_pin_i(sin),
    .shift_clock_pin_i(sclk_in), .shift_clock_pin_o(sclk_out),
    .shift_clock_pin_oe_o(sclk_oe));

  scc_ext_dev scc_ext_dev_i (
    .clk_i(clk_i), .serial_out_pin_i(sout), .serial_in_pin_o(sin),
    .shift_clock_pin_o(sclk_in));

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // hang guard, well above the few thousand cycles needed
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s,
                    output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, 4'hf, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    wb(1'b0, a, 32'h0, 4'hf, q);
  endtask

  task automatic t_regs;
    logic [31:0] q;
    rd(scc_pkg::CTRL_OFS, q);
    chk("ctrl_reset", 32'h0000_0600, q);
    rd(scc_pkg::MODE_OFS, q);
    chk("mode_reset", 32'h0, q);
    wr(scc_pkg::CTRL_OFS, 32'hffff_ffff);
    rd(scc_pkg::CTRL_OFS, q);
    chk("ctrl_rw", 32'h0000_7763, q);
    wb(1'b1, scc_pkg::CTRL_OFS, 32'h0, 4'h1, q);
    rd(scc_pkg::CTRL_OFS, q);
    chk("ctrl_lane", 32'h0000_7700, q);
    rd(8'h0c, q);
    chk("unmapped", 32'h0, q);
    $display("test regs done");
  endtask

  task automatic t_shift;
    logic [2:0]  code [5] = '{3'h3, 3'h6, 3'h1, 3'h0, 3'h0};
    int          hc [5] = '{16, 128, 4, 2, 2};
    logic [1:0]  idl [5] = '{scc_pkg::IDLE_HIGH, scc_pkg::IDLE_LOW,
                             scc_pkg::IDLE_LOW, scc_pkg::IDLE_KEEP,
                             scc_pkg::IDLE_LOW};
    logic        es [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
    logic [7:0]  byt [5] = '{8'h25, 8'ha5, 8'hc3, 8'hda, 8'hbc};
    logic        fin [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
    logic [7:0]  rx;
    logic [31:0] q;
    wr(scc_pkg::MODE_OFS, 32'h0);
    for (int k = 0; k < 5; k++) begin
      wr(scc_pkg::CTRL_OFS, {17'h0, code[k], 2'b01, idl[k], 6'h0,
                             es[k], 1'b1});
      scc_ext_dev_i.park(es[k]);
      wr(scc_pkg::DATA_OFS, {24'h0, byt[k]});
      scc_ext_dev_i.shift_byte(~byt[k], es[k], rx);
      chk("tx_byte", {24'h0, byt[k]}, {24'h0, rx});
      if (hc[k] >= 16) begin
        repeat (hc[k] - 8) @(posedge clk_i);
        chk("last_bit_held", {31'h0, byt[k][7]}, {31'h0, sout});
      end
      repeat (6) @(posedge clk_i);
      chk("idle_level", {31'h0, fin[k]}, {31'h0, sout});
      rd(scc_pkg::DATA_OFS, q);
      chk("rx_byte", {24'h0, ~byt[k]}, {24'h0, q[7:0]});
    end
    $display("test shift done");
  endtask

  task automatic t_underrun;
    logic [7:0]  rx;
    logic [31:0] q;
    rd(scc_pkg::DATA_OFS, q);
    for (int u = 0; u < 2; u++) begin
      // idle opposite to the under-run level keeps them apart
      wr(scc_pkg::CTRL_OFS, {21'h0, u[0], 1'b0, ~u[0], 8'h01});
      scc_ext_dev_i.park(1'b0);
      // first byte lands, second finds the fifo empty
      wr(scc_pkg::DATA_OFS, 32'h0000_005a);
      scc_ext_dev_i.shift_byte(8'h11 + u[7:0], 1'b0, rx);
      chk("tx_ext_byte", 32'h0000_005a, {24'h0, rx});
      scc_ext_dev_i.shift_byte(8'h00, 1'b0, rx);
      chk("underrun_level", {31'h0, u[0]}, {31'h0, sout});
      rd(scc_pkg::CTRL_OFS, q);
      chk("underrun_flag", 32'h1, {31'h0, q[scc_pkg::B_PARITY_UNDERRUN_FLAG]});
      chk("overrun_flag", {31'h0, u[0]}, {31'h0, q[scc_pkg::B_OVR]});
    end
    rd(scc_pkg::CTRL_OFS, q);
    chk("flags_cleared", 32'h0, {29'h0, q[4:2]});
    $display("test underrun done");
  endtask

  task automatic t_int_clk;
    int n;
    wr(scc_pkg::CTRL_OFS, 32'h0000_0100);
    repeat (2) @(posedge clk_i);
    chk("sclk_oe", 32'h1, {31'h0, sclk_oe});
    chk("sclk_idle", 32'h1, {31'h0, sclk_out});
    wr(scc_pkg::DATA_OFS, 32'h81);
    n = 0;
    while (sclk_out !== 1'b0 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    chk("sclk_runs", 32'h0, {31'h0, sclk_out});
    repeat (150) @(posedge clk_i);
    chk("sclk_back_idle", 32'h1, {31'h0, sclk_out});
    chk("out_idle_high", 32'h1, {31'h0, sout});
    wr(scc_pkg::CTRL_OFS, 32'h0000_0101);
    repeat (2) @(posedge clk_i);
    chk("sclk_oe_off", 32'h0, {31'h0, sclk_oe});
    $display("test internal clock done");
  endtask

  task automatic t_uart;
    logic [31:0] q;
    logic [8:0]  d;
    logic        pb;
    scc_ext_dev_i.line_idle();
    for (int m = 1; m < 3; m++) begin
      d = (m == 1) ? 9'h035 : 9'h0b5;
      wr(scc_pkg::MODE_OFS, m);
      for (int e = 0; e < 4; e++) begin
        wr(scc_pkg::CTRL_OFS, {25'h3, e[0], 6'h20});
        pb = (e[0] ? ^d : ~^d) ^ e[1];
        scc_ext_dev_i.uart_frame(d, (m == 1) ? 7 : 8, 1'b1, pb, 1'b1);
        rd(scc_pkg::CTRL_OFS, q);
        chk("parity_err", {31'h0, e[1]}, {31'h0, q[scc_pkg::B_PARITY_UNDERRUN_FLAG]});
        rd(scc_pkg::DATA_OFS, q);
        chk("rx_uart", {24'h0, d[7:0]}, {24'h0, q[7:0]});
      end
    end
    wr(scc_pkg::MODE_OFS, scc_pkg::MODE_U9);
    for (int n = 0; n < 3; n++) begin
      d = {n[0], 8'h3c};
      scc_ext_dev_i.uart_frame(d, 9, 1'b0, 1'b0, n < 2);
      rd(scc_pkg::CTRL_OFS, q);
      chk("ninth_bit", {31'h0, n[0]}, {31'h0, q[scc_pkg::B_NINTH]});
      chk("framing", {31'h0, n[1]}, {31'h0, q[scc_pkg::B_FRAMING_FLAG]});
      chk("no_parity_u9", 32'h0, {31'h0, q[scc_pkg::B_PARITY_UNDERRUN_FLAG]});
      rd(scc_pkg::DATA_OFS, q);
    end
    $display("test uart done");
  endtask

  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_shift();
    t_underrun();
    t_int_clk();
    t_uart();
    wrap_up();
  end
endmodule // tb_top

`default_nettype wire
